// file: common/trr_pkg.sv
/*
  trr_pkg: constants, register map and carrier types of the tariff rule
  result logic.
  assumes: one aclk domain; AXI4-Lite register access with 32-bit data.
*/
package trr_pkg;
  localparam int NUM_DAILY    = 32;
  localparam int NUM_WEEKLY   = 16;
  localparam int NUM_TARIFF   = 16;
  localparam int NUM_SEASON   = 16;
  localparam int NUM_HOLIDAY  = 32;
  localparam int NUM_DAYS     = 7;
  localparam int DREF_W       = 5;
  localparam int WREF_W       = 4;
  localparam int MINUTE_W     = 11;
  localparam int ADDR_W       = 12;

  // byte addresses; each group entry is one aligned word
  localparam logic [ADDR_W-1:0] DAILY_BASE   = 12'h000;
  localparam logic [ADDR_W-1:0] WEEKLY_BASE  = 12'h080;
  localparam logic [ADDR_W-1:0] STATUS_ADDR  = 12'h0C0;
  localparam logic [ADDR_W-1:0] TARIFF_BASE  = 12'h100;
  localparam logic [ADDR_W-1:0] DSTART_BASE  = 12'h200;
  localparam logic [ADDR_W-1:0] DEND_BASE    = 12'h280;
  localparam logic [ADDR_W-1:0] WREF_BASE    = 12'h300;
  localparam logic [ADDR_W-1:0] TWEEK_BASE   = 12'h400;
  localparam logic [ADDR_W-1:0] TSEAS_BASE   = 12'h440;
  localparam int               WREF_STRIDE   = 8;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] ZERO_WORD  = 32'h0000_0000;

  typedef struct packed {
    logic [MINUTE_W-1:0] minute;
    logic [2:0]          weekday;
  } trr_time_t;

  typedef struct packed {
    logic [MINUTE_W-1:0] start;
    logic [MINUTE_W-1:0] stop;
  } trr_daily_cfg_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              valid;
  } trr_req_t;
endpackage

// file: design/trr_rule_eval.sv
/*
  trr_rule_eval: combinational evaluation of daily, weekly and tariff rules.
  assumes: inputs settled in aclk domain; caller registers results.
*/
module trr_rule_eval
  import trr_pkg::*;
(
  input  wire trr_time_t                     now,
  input  wire logic                          holiday,
  input  wire logic [NUM_SEASON-1:0]         season,
  input  wire trr_daily_cfg_t [NUM_DAILY-1:0] daily_cfg,
  input  wire logic [NUM_WEEKLY-1:0][NUM_DAYS:0][DREF_W-1:0] wref,
  input  wire logic [NUM_TARIFF-1:0][WREF_W-1:0] tweek,
  input  wire logic [NUM_TARIFF-1:0][NUM_SEASON-1:0] tseas,
  output logic [NUM_DAILY-1:0]               daily,
  output logic [NUM_WEEKLY-1:0]              weekly,
  output logic [NUM_TARIFF-1:0]              tariff
);
  always_comb begin
    for (int d = 0; d < NUM_DAILY; d++) begin
      // start above stop wraps past midnight
      if (daily_cfg[d].start <= daily_cfg[d].stop) begin
        daily[d] = (now.minute >= daily_cfg[d].start) &&
                   (now.minute < daily_cfg[d].stop);
      end else begin
        daily[d] = (now.minute >= daily_cfg[d].start) ||
                   (now.minute < daily_cfg[d].stop);
      end
    end
    for (int w = 0; w < NUM_WEEKLY; w++) begin
      if (holiday) begin
        weekly[w] = daily[wref[w][NUM_DAYS]];
      end else if (now.weekday < 3'(NUM_DAYS)) begin
        weekly[w] = daily[wref[w][now.weekday]];
      end else begin
        weekly[w] = 1'b0;
      end
    end
    for (int t = 0; t < NUM_TARIFF; t++) begin
      tariff[t] = weekly[tweek[t]] && |(tseas[t] & season);
    end
  end
endmodule

// file: design/trr_top.sv
/*
  trr_top: tariff rule result logic with AXI4-Lite register slave.
  assumes: time, holiday and season inputs are synchronous to aclk;
  software programs rule parameters before relying on results.
*/
module trr_top
  import trr_pkg::*;
(
  input  wire  logic                   aclk,
  input  wire  logic                   aresetn,
  input  wire  trr_time_t              now,
  input  wire  logic [NUM_HOLIDAY-1:0] holiday_rule_result_array,
  input  wire  logic [NUM_SEASON-1:0]  seasonal_rule_result_array,
  input  wire  logic [ADDR_W-1:0]      s_axi_awaddr,
  input  wire  logic                   s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire  logic [31:0]            s_axi_wdata,
  input  wire  logic [3:0]             s_axi_wstrb,
  input  wire  logic                   s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire  logic                   s_axi_bready,
  input  wire  logic [ADDR_W-1:0]      s_axi_araddr,
  input  wire  logic                   s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire  logic                   s_axi_rready,
  output logic [NUM_TARIFF-1:0]        tariff_status_word
);
  typedef struct packed {
    logic [NUM_DAILY-1:0]                    daily;
    logic [NUM_WEEKLY-1:0]                   weekly;
    logic [NUM_TARIFF-1:0]                   tariff;
    trr_daily_cfg_t [NUM_DAILY-1:0]          dcfg;
    logic [NUM_WEEKLY-1:0][NUM_DAYS:0][DREF_W-1:0] wref;
    logic [NUM_TARIFF-1:0][WREF_W-1:0]       tweek;
    logic [NUM_TARIFF-1:0][NUM_SEASON-1:0]   tseas;
    trr_req_t                                aw;
    logic                                    wfull;
    logic [31:0]                             wdata;
    logic [3:0]                              wstrb;
    logic                                    bvalid;
    logic [1:0]                              bresp;
    logic                                    awready;
    logic                                    wready;
    logic                                    arready;
    logic                                    rvalid;
    logic [31:0]                             rdata;
    logic [1:0]                              rresp;
  } trr_state_t;

  trr_state_t st;
  trr_state_t next_st;

  logic [NUM_DAILY-1:0]  eval_daily;
  logic [NUM_WEEKLY-1:0] eval_weekly;
  logic [NUM_TARIFF-1:0] eval_tariff;
  logic                  holiday;

  // any active holiday rule marks today a holiday
  assign holiday = |holiday_rule_result_array;

  trr_rule_eval u_eval (
    .now       (now),
    .holiday   (holiday),
    .season    (seasonal_rule_result_array),
    .daily_cfg (st.dcfg),
    .wref      (st.wref),
    .tweek     (st.tweek),
    .tseas     (st.tseas),
    .daily     (eval_daily),
    .weekly    (eval_weekly),
    .tariff    (eval_tariff)
  );

  function automatic logic [31:0] rd_word(input trr_state_t s,
                                          input logic [ADDR_W-1:0] a,
                                          output logic hit);
    logic [31:0] v;
    logic [ADDR_W-1:0] off;
    v   = ZERO_WORD;
    hit = 1'b1;
    off = ADDR_W'(0);
    if (a >= DAILY_BASE && a < WEEKLY_BASE) begin
      v[0] = s.daily[a[6:2]];
    end else if (a >= WEEKLY_BASE && a < STATUS_ADDR) begin
      off  = a - WEEKLY_BASE;
      v[0] = s.weekly[off[5:2]];
    end else if (a == STATUS_ADDR) begin
      v[NUM_TARIFF-1:0] = s.tariff;
    end else if (a >= TARIFF_BASE && a < TARIFF_BASE + 12'h040) begin
      off  = a - TARIFF_BASE;
      v[0] = s.tariff[off[5:2]];
    end else if (a >= DSTART_BASE && a < DEND_BASE) begin
      off = a - DSTART_BASE;
      v[MINUTE_W-1:0] = s.dcfg[off[6:2]].start;
    end else if (a >= DEND_BASE && a < WREF_BASE) begin
      off = a - DEND_BASE;
      v[MINUTE_W-1:0] = s.dcfg[off[6:2]].stop;
    end else if (a >= WREF_BASE && a < TWEEK_BASE) begin
      off = a - WREF_BASE;
      if (off[1:0] == 2'h0) begin
        v[DREF_W-1:0] = s.wref[off[8:5]][off[4:2]];
      end else begin
        hit = 1'b0;
      end
    end else if (a >= TWEEK_BASE && a < TSEAS_BASE) begin
      off = a - TWEEK_BASE;
      v[WREF_W-1:0] = s.tweek[off[5:2]];
    end else if (a >= TSEAS_BASE && a < TSEAS_BASE + 12'h040) begin
      off = a - TSEAS_BASE;
      v[NUM_SEASON-1:0] = s.tseas[off[5:2]];
    end else begin
      hit = 1'b0;
    end
    if (a[1:0] != 2'h0) begin
      hit = 1'b0;
    end
    return hit ? v : ZERO_WORD;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction

  always_comb begin
    logic [ADDR_W-1:0] off;
    logic [31:0]       cur;
    logic              hit;
    logic              do_wr;
    next_st = st;
    off     = ADDR_W'(0);
    cur     = ZERO_WORD;
    hit     = 1'b0;
    do_wr   = 1'b0;
    // results re-evaluated every cycle from live inputs
    next_st.daily  = eval_daily;
    next_st.weekly = eval_weekly;
    next_st.tariff = eval_tariff;

    // write channel: address and data may arrive in either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_st.aw.addr  = s_axi_awaddr;
      next_st.aw.valid = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_st.wfull = 1'b1;
      next_st.wdata = s_axi_wdata;
      next_st.wstrb = s_axi_wstrb;
    end
    if (st.aw.valid && st.wfull && !st.bvalid) begin
      do_wr = 1'b1;
      next_st.aw.valid = 1'b0;
      next_st.wfull    = 1'b0;
      next_st.bvalid   = 1'b1;
      cur = rd_word(st, st.aw.addr, hit);
      next_st.bresp = RESP_SLVERR;
    end
    if (do_wr) begin
      if (st.aw.addr[1:0] == 2'h0) begin
        cur = merge(cur, st.wdata, st.wstrb);
        if (st.aw.addr >= DSTART_BASE && st.aw.addr < DEND_BASE) begin
          off = st.aw.addr - DSTART_BASE;
          next_st.dcfg[off[6:2]].start = cur[MINUTE_W-1:0];
          next_st.bresp = RESP_OKAY;
        end else if (st.aw.addr >= DEND_BASE && st.aw.addr < WREF_BASE) begin
          off = st.aw.addr - DEND_BASE;
          next_st.dcfg[off[6:2]].stop = cur[MINUTE_W-1:0];
          next_st.bresp = RESP_OKAY;
        end else if (st.aw.addr >= WREF_BASE && st.aw.addr < TWEEK_BASE &&
                     hit) begin
          off = st.aw.addr - WREF_BASE;
          next_st.wref[off[8:5]][off[4:2]] = cur[DREF_W-1:0];
          next_st.bresp = RESP_OKAY;
        end else if (st.aw.addr >= TWEEK_BASE &&
                     st.aw.addr < TSEAS_BASE) begin
          off = st.aw.addr - TWEEK_BASE;
          next_st.tweek[off[5:2]] = cur[WREF_W-1:0];
          next_st.bresp = RESP_OKAY;
        end else if (st.aw.addr >= TSEAS_BASE &&
                     st.aw.addr < TSEAS_BASE + 12'h040) begin
          off = st.aw.addr - TSEAS_BASE;
          next_st.tseas[off[5:2]] = cur[NUM_SEASON-1:0];
          next_st.bresp = RESP_OKAY;
        end
      end
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end

    // read channel: one outstanding read
    next_st.arready = !st.rvalid && !(s_axi_arvalid && st.arready);
    if (s_axi_arvalid && st.arready) begin
      next_st.rdata  = rd_word(st, s_axi_araddr, hit);
      next_st.rresp  = hit ? RESP_OKAY : RESP_SLVERR;
      next_st.rvalid = 1'b1;
    end
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid  = 1'b0;
      next_st.arready = 1'b1;
    end
    // ready flags held in flops so the ports need no inverter
    next_st.awready = !next_st.aw.valid;
    next_st.wready  = !next_st.wfull;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign s_axi_awready      = st.awready;
  assign s_axi_wready       = st.wready;
  assign s_axi_bvalid       = st.bvalid;
  assign s_axi_bresp        = st.bresp;
  assign s_axi_arready      = st.arready;
  assign s_axi_rvalid       = st.rvalid;
  assign s_axi_rdata        = st.rdata;
  assign s_axi_rresp        = st.rresp;
  assign tariff_status_word = st.tariff;
endmodule

// file: verif/trr_properties.sv
/*
  trr_properties: port-level checks of the tariff rule result block.
  assumes: bound to trr_top; one aclk domain, sync active-low reset.
*/
module trr_properties
  import trr_pkg::*;
(
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire logic [ADDR_W-1:0]     s_axi_araddr,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic [31:0]           s_axi_rdata,
  input wire logic [1:0]            s_axi_rresp,
  input wire logic                  s_axi_rvalid,
  input wire logic                  s_axi_rready,
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_bready,
  input wire logic [NUM_TARIFF-1:0] tariff_status_word
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_ar;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_ok_bit;
    s_axi_rdata[31:1] == 31'h0 && s_axi_rresp == RESP_OKAY;
  endsequence
  property p_reset;
    disable iff (1'b0) !aresetn |=> tariff_status_word == 16'h0000
      && !s_axi_rvalid && !s_axi_bvalid;
  endproperty
  property p_rd_answer;
    s_ar |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  property p_r_stands;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_b_stands;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  property p_daily_bit;
    s_ar ##0 (s_axi_araddr < WEEKLY_BASE && s_axi_araddr[1:0] == 2'h0)
      |=> s_ok_bit;
  endproperty
  property p_weekly_bit;
    s_ar ##0 (s_axi_araddr >= WEEKLY_BASE && s_axi_araddr < STATUS_ADDR
      && s_axi_araddr[1:0] == 2'h0) |=> s_ok_bit;
  endproperty
  property p_status_read;
    s_ar ##0 s_axi_araddr == STATUS_ADDR ##1 $stable(tariff_status_word)
      |-> s_axi_rdata == {16'h0000, tariff_status_word};
  endproperty
  property p_unaligned;
    s_ar ##0 s_axi_araddr[1:0] != 2'h0
      |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == ZERO_WORD;
  endproperty
  a_reset: assert property (p_reset)
    else $error("results not cleared by reset");
  a_rd_answer: assert property (p_rd_answer)
    else $error("read answer late");
  a_r_stands: assert property (p_r_stands)
    else $error("read data dropped");
  a_b_stands: assert property (p_b_stands)
    else $error("write response dropped");
  a_daily_bit: assert property (p_daily_bit)
    else $error("daily result not 0 or 1");
  a_weekly_bit: assert property (p_weekly_bit)
    else $error("weekly result not 0 or 1");
  a_status_read: assert property (p_status_read)
    else $error("status read differs from port");
  a_unaligned: assert property (p_unaligned)
    else $error("unaligned read not refused");
endmodule

// file: verif/trr_top_tb.sv
/*
  trr_top_tb: random and corner tests of the tariff rule result block.
  assumes: trr_top with AXI4-Lite slave; 125 MHz aclk.
*/
module trr_top_tb;
  import trr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
  logic [11:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, seed = 32'h0000_49A2, rdv, rdw, ex[7];
  logic [1:0] rsp, br, rr;
  logic [15:0] ssn = 0, tsw;
  logic [31:0] hol = 0;
  trr_time_t now_t = '0;
  logic [11:0] ad[7] = '{12'h000, 12'h004, 12'h07C, 12'h080, 12'h0BC,
                         12'h0C0, 12'h100};
  int checks = 0, miscompares = 0, m, dw;
  logic h, d0, d1, d2, w0;
  logic aw_r, w_r, ar_r, bv, rv;
  always #4 aclk = ~aclk;
  trr_top dut_u (.aclk(aclk), .aresetn(aresetn), .now(now_t),
    .holiday_rule_result_array(hol), .seasonal_rule_result_array(ssn),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(aw_r),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(w_r), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(ar_r), .s_axi_rdata(rdw), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(rre), .tariff_status_word(tsw));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // equal start and stop means the rule never fires
  function automatic logic dact(int s, int e, int t);
    return s < e ? (t >= s && t < e) : (s > e && (t >= s || t < e));
  endfunction
  task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s exp %h seen %h", n, exp, seen);
    end
  endtask
  // readies and answers taken at the falling edge, where they are settled
  task automatic wr(logic [11:0] a, logic [31:0] d, output logic [1:0] r);
    logic aw_t;
    logic w_t;
    logic b_t;
    awa <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    bre <= 1;
    do begin
      @(negedge aclk);
      aw_t = awv && aw_r;
      w_t = wv && w_r;
      b_t = bv;
      r = br;
      @(posedge aclk);
      if (aw_t) awv <= 0;
      if (w_t) wv <= 0;
    end while (!b_t);
    bre <= 0;
    // one idle edge keeps the next call off this time step
    @(posedge aclk);
  endtask
  task automatic rd(logic [11:0] a, output logic [31:0] d);
    logic ar_t;
    logic r_t;
    ara <= a;
    arv <= 1;
    rre <= 1;
    do begin
      @(negedge aclk);
      ar_t = arv && ar_r;
      r_t = rv;
      d = rdw;
      rsp = rr;
      @(posedge aclk);
      if (ar_t) arv <= 0;
    end while (!r_t);
    rre <= 0;
    @(posedge aclk);
  endtask
  task automatic finish_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    finish_test();
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    repeat (2) @(posedge aclk);
    rd(STATUS_ADDR, rdv);
    chk("status after reset", rdv, ZERO_WORD);
    wr(DSTART_BASE, 100, rsp);
    chk("config write resp", 32'(rsp), 32'(RESP_OKAY));
    wr(DEND_BASE, 200, rsp);
    wr(DSTART_BASE + 12'h004, 1300, rsp);
    wr(DEND_BASE + 12'h004, 60, rsp);
    wr(DSTART_BASE + 12'h008, 600, rsp);
    wr(DEND_BASE + 12'h008, 900, rsp);
    for (int d = 0; d < 8; d++)
      wr(WREF_BASE + 12'(4 * d), d == 7 ? 2 : d % 2, rsp);
    wr(TSEAS_BASE, 32'h0000_0005, rsp);
    wr(DAILY_BASE, 1, rsp);
    chk("write to result", 32'(rsp), 32'(RESP_SLVERR));
    $display("setup test done");
    for (int i = 0; i < 40; i++) begin
      // passes 1 to 3 sit on the rule edges 100, 200 and 1300
      m = i < 9 ? int'(ad[i % 7]) * 0 + (i * 180 + 59) % 1440
                : int'(rnd() % 1440);
      if (i == 1) m = 100;
      if (i == 2) m = 200;
      if (i == 3) m = 1300;
      dw = int'(rnd() % 8);
      h = rnd() % 3 == 0;
      hol <= h ? 32'h1 << (rnd() % 32) : 32'h0;
      ssn <= 16'(rnd());
      now_t <= '{minute: 11'(m), weekday: 3'(dw)};
      repeat (2) @(posedge aclk);
      d0 = dact(100, 200, m);
      d1 = dact(1300, 60, m);
      d2 = dact(600, 900, m);
      // weekday 7 names no day, so only a holiday gives a result then
      w0 = h ? d2 : (dw == 7 ? 1'b0 : (dw % 2 ? d1 : d0));
      ex = '{32'(d0), 32'(d1), 0, 32'(w0), 32'((h || dw < 7) && d0),
             32'(w0 && |(ssn & 5)), 32'(w0 && |(ssn & 5))};
      for (int k = 0; k < 7; k++) begin
        rd(ad[k], rdv);
        chk($sformatf("reg %h", ad[k]), rdv, ex[k]);
      end
      chk("status port", 32'(tsw), ex[5]);
    end
    $display("random test done");
    rd(12'hFFC, rdv);
    chk("unmapped resp", 32'(rsp), 32'(RESP_SLVERR));
    chk("unmapped data", rdv, ZERO_WORD);
    // tariff 0 active before the mid-run reset, so clearing shows
    hol <= 32'h0000_0000;
    ssn <= 16'h0001;
    now_t <= '{minute: 11'h096, weekday: 3'h0};
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk("status before reset", 32'(tsw), 32'h0000_0001);
    @(posedge aclk);
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk("status after 2nd reset", 32'(tsw), ZERO_WORD);
    $display("reset test done");
    finish_test();
  end
endmodule
bind trr_top trr_properties chk_u (.aclk(aclk), .aresetn(aresetn),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .tariff_status_word(tariff_status_word));
